// ### hw/scg_pkg.sv
// shared constants for the sleep-mode clock gate bank
package scg_pkg;

  // ------------------------------------------------------------
  // bus and register map
  // ------------------------------------------------------------
  localparam int unsigned SCG_DATA_W = 32;
  localparam int unsigned SCG_ADDR_W = 12;
  localparam logic [31:0] SCG_SYSCTL_BASE = 32'h400f_e000;
  localparam logic [11:0] SCG_OFF_RUN_CFG = 12'h060;
  localparam logic [11:0] SCG_OFF_RUN_GATE = 12'h104;
  localparam logic [11:0] SCG_OFF_SLEEP_GATE = 12'h114;
  localparam logic [11:0] SCG_OFF_DEEP_GATE = 12'h124;
  localparam logic [11:0] SCG_OFF_IRQ_STATUS = 12'h200;
  localparam logic [11:0] SCG_OFF_IRQ_MASK = 12'h204;

  // ------------------------------------------------------------
  // field layout and reset values
  // ------------------------------------------------------------
  localparam logic [31:0] SCG_GATE_RESET = 32'h0000_0000;
  localparam logic [31:0] SCG_GATE_WMASK = 32'h070f_5137;
  localparam int unsigned SCG_AUTO_GATING_BIT = 0;
  localparam logic [31:0] SCG_RUN_CFG_WMASK = 32'h0000_0001;
  localparam logic [31:0] SCG_RUN_CFG_RESET = 32'h0000_0000;
  localparam int unsigned SCG_IRQ_W = 2;
  localparam int unsigned SCG_IRQ_FAULT = 0;
  localparam int unsigned SCG_IRQ_SRC_CHANGE = 1;
  localparam logic [1:0] SCG_IRQ_RESET = 2'h0;

  // gate bit positions of the units
  localparam int unsigned SCG_BIT_COMPARATOR_2 = 26;
  localparam int unsigned SCG_BIT_COMPARATOR_0 = 24;
  localparam int unsigned SCG_BIT_GP_COUNTER_3 = 19;
  localparam int unsigned SCG_BIT_GP_COUNTER_0 = 16;
  localparam int unsigned SCG_BIT_TWO_WIRE_1 = 14;
  localparam int unsigned SCG_BIT_TWO_WIRE_0 = 12;
  localparam int unsigned SCG_BIT_QUAD_ENCODER_0 = 8;
  localparam int unsigned SCG_BIT_SYNC_SERIAL_1 = 5;
  localparam int unsigned SCG_BIT_SYNC_SERIAL_0 = 4;
  localparam int unsigned SCG_BIT_ASYNC_SERIAL_2 = 2;
  localparam int unsigned SCG_BIT_ASYNC_SERIAL_0 = 0;

  // ------------------------------------------------------------
  // gating source
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SCG_SRC_RUN = 3'b001,
    SCG_SRC_SLEEP = 3'b010,
    SCG_SRC_DEEP = 3'b100
  } scg_src_t;

endpackage

// ### hw/scg_enable_switch.sv
// selects the gating source and registers the unit clock enables
`timescale 1ns/1ps
`default_nettype none
module scg_enable_switch
  import scg_pkg::*;
#(
  parameter int unsigned WIDTH = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] run_gate,
  input wire logic [WIDTH-1:0] sleep_gate,
  input wire logic [WIDTH-1:0] deep_gate,
  input wire logic auto_gating,
  input wire logic sleep_active,
  input wire logic deep_sleep_active,
  output logic [WIDTH-1:0] clk_en_q,
  output logic src_change_q
);

  scg_src_t src_d, src_q;
  logic [WIDTH-1:0] clk_en_d;
  logic src_change_d;

  // ------------------------------------------------------------
  // source choice
  // ------------------------------------------------------------
  always_comb begin
    if (auto_gating && deep_sleep_active) begin
      src_d = SCG_SRC_DEEP;
    end else if (auto_gating && sleep_active) begin
      src_d = SCG_SRC_SLEEP;
    end else begin
      src_d = SCG_SRC_RUN;
    end
    // enables change only at an edge, so units never see a runt pulse
    unique case (src_d)
      SCG_SRC_SLEEP: clk_en_d = sleep_gate;
      SCG_SRC_DEEP: clk_en_d = deep_gate;
      SCG_SRC_RUN: clk_en_d = run_gate;
    endcase
    src_change_d = (src_d != src_q);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= SCG_SRC_RUN;
      clk_en_q <= '0;
      src_change_q <= 1'b0;
    end else begin
      src_q <= src_d;
      clk_en_q <= clk_en_d;
      src_change_q <= src_change_d;
    end
  end

endmodule
`default_nettype wire

// ### hw/scg_fault_check.sv
// answers unit accesses with a fault when the unit is unclocked
`timescale 1ns/1ps
`default_nettype none
module scg_fault_check #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned IDX_W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] clk_en,
  input wire logic unit_access_valid,
  input wire logic [IDX_W-1:0] unit_access_idx,
  output logic unit_done_q,
  output logic unit_fault_q
);

  logic unit_done_d;
  logic unit_fault_d;

  // every gate bit must be reachable by an index
  if (WIDTH > (1 << IDX_W)) begin : g_bad_idx_w
    $error("index too narrow for gate width");
  end

  always_comb begin
    unit_done_d = unit_access_valid;
    unit_fault_d = 1'b0;
    if (unit_access_valid) begin
      // out-of-range or unclocked unit both fault
      if (32'(unit_access_idx) >= WIDTH) begin
        unit_fault_d = 1'b1;
      end else begin
        unit_fault_d = !clk_en[unit_access_idx];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_done_q <= 1'b0;
      unit_fault_q <= 1'b0;
    end else begin
      unit_done_q <= unit_done_d;
      unit_fault_q <= unit_fault_d;
    end
  end

endmodule
`default_nettype wire

// ### hw/scg_gate_bank.sv
// apb register bank for run, sleep and deep-sleep clock gating
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - sleep gate register at offset 0x114
// - set bit clocks unit, clear stops it
// - access to unclocked unit gives bus fault
// - register resets to zero, all unclocked
// - sleep values apply only during sleep
// - sleep values need auto gating bit set
// - bits 26:24 gate comparators 2..0
// - bits 19:16 gate timers 3..0
// - bits 14 and 12 gate two-wire units
// - bit 8 gates quadrature encoder 0
// - reserved bits read zero, ignore writes
// - bits 5:4 sync serial, 2:0 async
module scg_gate_bank
  import scg_pkg::*;
#(
  parameter int unsigned GATE_W = 32,
  parameter int unsigned IDX_W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [SCG_ADDR_W-1:0] paddr,
  input wire logic [SCG_DATA_W-1:0] pwdata,
  output logic [SCG_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_active,
  input wire logic deep_sleep_active,
  output logic [GATE_W-1:0] unit_clk_en,
  input wire logic unit_access_valid,
  input wire logic [IDX_W-1:0] unit_access_idx,
  output logic unit_done,
  output logic unit_fault,
  output logic irq
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  // gate words are bus words, one bit per unit
  if (GATE_W != SCG_DATA_W) begin : g_bad_gate_w
    $error("gate width must equal bus width");
  end

  // ------------------------------------------------------------
  // register selection
  // ------------------------------------------------------------
  localparam int unsigned N_REG = 6;
  localparam int unsigned SEL_RUN_CFG = 0;
  localparam int unsigned SEL_RUN_GATE = 1;
  localparam int unsigned SEL_SLEEP_GATE = 2;
  localparam int unsigned SEL_DEEP_GATE = 3;
  localparam int unsigned SEL_IRQ_STATUS = 4;
  localparam int unsigned SEL_IRQ_MASK = 5;
  // gate words follow select order, so word g answers to select SEL_RUN_GATE + g
  localparam int unsigned N_GATE = 3;
  localparam int unsigned G_RUN = 0;
  localparam int unsigned G_SLEEP = 1;
  localparam int unsigned G_DEEP = 2;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [31:0] run_cfg_q, run_cfg_d;
  logic [31:0] gate_word [N_GATE];
  logic [SCG_IRQ_W-1:0] irq_status_q, irq_status_d;
  logic [SCG_IRQ_W-1:0] irq_mask_q, irq_mask_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic irq_q, irq_d;
  logic [GATE_W-1:0] clk_en_w;
  logic src_change_w;
  logic fault_w;
  logic done_w;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  function automatic logic [N_REG-1:0] reg_sel(input logic [SCG_ADDR_W-1:0] a);
    reg_sel = '0;
    reg_sel[SEL_RUN_CFG] = (a == SCG_OFF_RUN_CFG);
    reg_sel[SEL_RUN_GATE] = (a == SCG_OFF_RUN_GATE);
    reg_sel[SEL_SLEEP_GATE] = (a == SCG_OFF_SLEEP_GATE);
    reg_sel[SEL_DEEP_GATE] = (a == SCG_OFF_DEEP_GATE);
    reg_sel[SEL_IRQ_STATUS] = (a == SCG_OFF_IRQ_STATUS);
    reg_sel[SEL_IRQ_MASK] = (a == SCG_OFF_IRQ_MASK);
  endfunction

  function automatic logic [31:0] gate_write(input logic [31:0] old, input logic [31:0] wd);
    // reserved bits stay zero whatever software writes
    gate_write = (wd & SCG_GATE_WMASK) | (old & ~SCG_GATE_WMASK);
  endfunction

  logic [N_REG-1:0] sel;
  logic setup_phase;
  logic access_done;
  logic wr_en;
  logic rd_en;

  always_comb begin
    sel = reg_sel(paddr);
    setup_phase = psel && !penable;
    access_done = psel && penable && pready_q;
    wr_en = access_done && pwrite && !pslverr_q;
    rd_en = access_done && !pwrite && !pslverr_q;
  end

  // ------------------------------------------------------------
  // apb handshake: registered, one wait-free access phase
  // ------------------------------------------------------------
  always_comb begin
    pready_d = setup_phase;
    // unmapped offsets answer with an error and leave every register alone
    pslverr_d = setup_phase && !(|sel);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ------------------------------------------------------------
  // read data: captured in setup, shown in the access cycle only
  // ------------------------------------------------------------
  always_comb begin
    prdata_d = '0;
    if (setup_phase && !pwrite) begin
      unique if (sel[SEL_RUN_CFG]) begin
        prdata_d = run_cfg_q;
      end else if (sel[SEL_RUN_GATE]) begin
        prdata_d = gate_word[G_RUN];
      end else if (sel[SEL_SLEEP_GATE]) begin
        prdata_d = gate_word[G_SLEEP];
      end else if (sel[SEL_DEEP_GATE]) begin
        prdata_d = gate_word[G_DEEP];
      end else if (sel[SEL_IRQ_STATUS]) begin
        prdata_d = 32'(irq_status_q);
      end else if (sel[SEL_IRQ_MASK]) begin
        prdata_d = 32'(irq_mask_q);
      end else begin
        prdata_d = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // ------------------------------------------------------------
  // run configuration and interrupt mask
  // ------------------------------------------------------------
  always_comb begin
    run_cfg_d = run_cfg_q;
    irq_mask_d = irq_mask_q;
    if (wr_en && sel[SEL_RUN_CFG]) begin
      run_cfg_d = pwdata & SCG_RUN_CFG_WMASK;
    end
    if (wr_en && sel[SEL_IRQ_MASK]) begin
      irq_mask_d = pwdata[SCG_IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cfg_q <= SCG_RUN_CFG_RESET;
      irq_mask_q <= SCG_IRQ_RESET;
    end else begin
      run_cfg_q <= run_cfg_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // ------------------------------------------------------------
  // gating registers: run, sleep and deep-sleep words alike
  // ------------------------------------------------------------
  for (genvar g = 0; g < N_GATE; g++) begin : g_gate
    logic [31:0] word_q, word_d;

    always_comb begin
      word_d = word_q;
      // comparators, timers, two-wire, encoder, serial units
      if (wr_en && sel[SEL_RUN_GATE + g]) begin
        word_d = gate_write(word_q, pwdata);
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        word_q <= SCG_GATE_RESET;
      end else begin
        word_q <= word_d;
      end
    end

    assign gate_word[g] = word_q;
  end

  // ------------------------------------------------------------
  // source switch and fault check
  // ------------------------------------------------------------
  scg_enable_switch #(
    .WIDTH(GATE_W)
  ) u_switch (
    .pclk(pclk),
    .presetn(presetn),
    .run_gate(gate_word[G_RUN]),
    .sleep_gate(gate_word[G_SLEEP]),
    .deep_gate(gate_word[G_DEEP]),
    .auto_gating(run_cfg_q[SCG_AUTO_GATING_BIT]),
    .sleep_active(sleep_active),
    .deep_sleep_active(deep_sleep_active),
    .clk_en_q(clk_en_w),
    .src_change_q(src_change_w)
  );

  scg_fault_check #(
    .WIDTH(GATE_W),
    .IDX_W(IDX_W)
  ) u_fault (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en_w),
    .unit_access_valid(unit_access_valid),
    .unit_access_idx(unit_access_idx),
    .unit_done_q(done_w),
    .unit_fault_q(fault_w)
  );

  // ------------------------------------------------------------
  // interrupt: sticky status, cleared by read, set wins
  // ------------------------------------------------------------
  logic status_rd;
  logic [SCG_IRQ_W-1:0] irq_set;

  always_comb begin
    status_rd = rd_en && sel[SEL_IRQ_STATUS];
    irq_set = '0;
    irq_set[SCG_IRQ_FAULT] = fault_w;
    irq_set[SCG_IRQ_SRC_CHANGE] = src_change_w;
  end

  for (genvar s = 0; s < SCG_IRQ_W; s++) begin : g_status
    logic bit_q, bit_d;

    always_comb begin
      // an event in the clearing cycle must not be lost
      bit_d = (bit_q && !status_rd) || irq_set[s];
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        bit_q <= SCG_IRQ_RESET[s];
      end else begin
        bit_q <= bit_d;
      end
    end

    assign irq_status_q[s] = bit_q;
    assign irq_status_d[s] = bit_d;
  end

  always_comb begin
    irq_d = |(irq_status_d & irq_mask_d);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_comb begin
    prdata = prdata_q;
    pready = pready_q;
    pslverr = pslverr_q;
    unit_clk_en = clk_en_w;
    unit_done = done_w;
    unit_fault = fault_w;
    irq = irq_q;
  end

endmodule
`default_nettype wire

// ### testbench/scg_unit_model.sv
// unit-side model that issues one-cycle accesses to the gated units
`timescale 1ns/1ps
`default_nettype none
module scg_unit_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic [4:0] req_idx,
  output logic unit_access_valid,
  output logic [4:0] unit_access_idx
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_access_valid <= 1'b0;
      unit_access_idx <= 5'h0;
    end else begin
      unit_access_valid <= req;
      // idle index keeps moving so a stale target is never seen
      unit_access_idx <= req ? req_idx : ~unit_access_idx;
    end
  end
endmodule
`default_nettype wire

// ### testbench/scg_gate_bank_chk.sv
// port-level assertions for the clock gate bank
`timescale 1ns/1ps
`default_nettype none
module scg_gate_bank_chk
  import scg_pkg::*;
#(
  parameter int unsigned GATE_W = 32,
  parameter int unsigned IDX_W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [SCG_ADDR_W-1:0] paddr,
  input wire logic [SCG_DATA_W-1:0] pwdata,
  input wire logic [SCG_DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep_active,
  input wire logic deep_sleep_active,
  input wire logic [GATE_W-1:0] unit_clk_en,
  input wire logic unit_access_valid,
  input wire logic [IDX_W-1:0] unit_access_idx,
  input wire logic unit_done,
  input wire logic unit_fault,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && !penable |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_map; pready && !pwrite && paddr == SCG_OFF_SLEEP_GATE |-> (prdata & ~SCG_GATE_WMASK) == 32'h0; endproperty
  property p_en; (unit_clk_en & ~SCG_GATE_WMASK) == 32'h0; endproperty
  property p_rst; $rose(presetn) |-> unit_clk_en == 32'h0; endproperty
  property p_done; unit_access_valid |=> unit_done; endproperty
  property p_off; unit_access_valid && !unit_clk_en[unit_access_idx] |=> unit_fault; endproperty
  property p_on; unit_access_valid && unit_clk_en[unit_access_idx] |=> !unit_fault; endproperty
  property p_fd; unit_fault |-> unit_done; endproperty
  property p_err; pslverr |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("ready missing");
  a_pulse: assert property (p_pulse) else $error("ready too long");
  a_map: assert property (p_map) else $error("reserved bit read");
  a_en: assert property (p_en) else $error("reserved enable");
  a_rst: assert property (p_rst) else $error("enable after reset");
  a_done: assert property (p_done) else $error("no unit done");
  a_off: assert property (p_off) else $error("missing fault");
  a_on: assert property (p_on) else $error("false fault");
  a_fd: assert property (p_fd) else $error("fault without done");
  a_err: assert property (p_err) else $error("error without ready");
  c_fault: cover property (unit_fault);
  c_err: cover property (pslverr);
  c_irq: cover property (irq);
endmodule
bind scg_gate_bank scg_gate_bank_chk #(.GATE_W(GATE_W), .IDX_W(IDX_W)) scg_gate_bank_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sleep_active(sleep_active), .deep_sleep_active(deep_sleep_active), .unit_clk_en(unit_clk_en),
  .unit_access_valid(unit_access_valid), .unit_access_idx(unit_access_idx),
  .unit_done(unit_done), .unit_fault(unit_fault), .irq(irq)
);
`default_nettype wire

// ### testbench/tb_scg_gate_bank.sv
// self-checking testbench for the clock gate bank
`timescale 1ns/1ps
`default_nettype none
module tb_scg_gate_bank;
  import scg_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic slp = 1'b0, dslp = 1'b0, req = 1'b0, pready, pslverr, uv, udone, ufault, irq, e;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, clk_en, r;
  logic [4:0] uidx, ridx = 5'h0;
  int n_fail = 0, n_checks = 0;
  scg_gate_bank scg_gate_bank_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_active(slp), .deep_sleep_active(dslp), .unit_clk_en(clk_en), .unit_access_valid(uv),
    .unit_access_idx(uidx), .unit_done(udone), .unit_fault(ufault), .irq(irq));
  scg_unit_model scg_unit_model_inst (.pclk(pclk), .presetn(presetn), .req(req), .req_idx(ridx),
    .unit_access_valid(uv), .unit_access_idx(uidx));
  initial forever #5 pclk = ~pclk;
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin n_fail++; print_verdict(); end
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic uacc(input logic [4:0] i, input logic f);
    int k;
    k = 0;
    @(posedge pclk);
    req <= 1'b1; ridx <= i;
    @(posedge pclk);
    req <= 1'b0;
    do begin @(posedge pclk); k++; end while (udone !== 1'b1 && k < 8);
    if (udone !== 1'b1) begin n_fail++; print_verdict(); end
    chk("unit_done", {31'h0, udone}, 32'h1);
    chk("unit_fault", {31'h0, ufault}, {31'h0, f});
  endtask
  // enable path is two edges from write, one from mode change; settle waits three
  task automatic settle(input logic [31:0] exp);
    repeat (3) @(posedge pclk);
    chk("unit_clk_en", clk_en, exp);
  endtask
  task automatic t_map();
    apb(1'b0, SCG_OFF_SLEEP_GATE, 32'h0);
    chk("sleep reset", r, 32'h0);
    chk("clk_en reset", clk_en, 32'h0);
    for (int b = 0; b < 32; b++) begin
      apb(1'b1, SCG_OFF_SLEEP_GATE, 32'h1 << b);
      apb(1'b0, SCG_OFF_SLEEP_GATE, 32'h0);
      chk("sleep bit", r, (32'h1 << b) & SCG_GATE_WMASK);
    end
    apb(1'b1, SCG_OFF_SLEEP_GATE, 32'hffff_ffff);
    apb(1'b1, SCG_OFF_RUN_GATE, 32'h0);
    apb(1'b0, SCG_OFF_SLEEP_GATE, 32'h0);
    chk("sleep kept", r, SCG_GATE_WMASK);
    apb(1'b1, 12'h118, 32'h1);
    chk("slverr", {31'h0, e}, 32'h1);
  endtask
  task automatic t_select();
    apb(1'b1, SCG_OFF_RUN_GATE, 32'h0000_0011);
    apb(1'b1, SCG_OFF_SLEEP_GATE, 32'h0100_1000);
    apb(1'b1, SCG_OFF_DEEP_GATE, 32'h0008_0004);
    @(posedge pclk) slp <= 1'b1;
    settle(32'h0000_0011);
    apb(1'b1, SCG_OFF_RUN_CFG, 32'h1);
    settle(32'h0100_1000);
    @(posedge pclk) dslp <= 1'b1;
    settle(32'h0008_0004);
    @(posedge pclk) begin dslp <= 1'b0; slp <= 1'b0; end
    settle(32'h0000_0011);
  endtask
  task automatic t_irq();
    apb(1'b0, SCG_OFF_IRQ_STATUS, 32'h0);
    chk("status src", r, 32'h2);
    uacc(5'd4, 1'b0);
    uacc(5'd1, 1'b1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, SCG_OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1'b0, SCG_OFF_IRQ_STATUS, 32'h0);
    chk("status", r, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
  endtask
  task automatic t_rerst();
    @(posedge pclk) presetn <= 1'b0;
    @(posedge pclk) presetn <= 1'b1;
    apb(1'b0, SCG_OFF_RUN_GATE, 32'h0);
    chk("run reset", r, 32'h0);
    chk("clk_en rerst", clk_en, 32'h0);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_map();
    t_select();
    t_irq();
    t_rerst();
    print_verdict();
  end
endmodule
`default_nettype wire
